/* File: rtl/atadma_pkg.sv */
// Constants, types and helpers shared by the bus-master DMA control block
package atadma_pkg;

   // ----------------------------------------------------------------
   // Register word indices (byte address is four times the index)
   // ----------------------------------------------------------------
   localparam int unsigned IDX_W          = 10;
   localparam logic [9:0]  IDX_DMA_CMD    = 10'h000;
   localparam logic [9:0]  IDX_DMA_STAT   = 10'h002;
   localparam logic [9:0]  IDX_DESC_PTR   = 10'h004;
   localparam logic [9:0]  IDX_WAIT_TMR   = 10'h03C;
   localparam logic [9:0]  IDX_DECODE     = 10'h040;
   localparam logic [9:0]  IDX_LINE_STAT  = 10'h047;

   // ----------------------------------------------------------------
   // Field positions
   // ----------------------------------------------------------------
   localparam int unsigned CMD_GO_BIT     = 0;
   localparam int unsigned CMD_DIR_BIT    = 3;
   localparam int unsigned ST_ACT_BIT     = 0;
   localparam int unsigned ST_ERR_BIT     = 1;
   localparam int unsigned ST_IRQ_BIT     = 2;
   localparam int unsigned ST_WTO_BIT     = 3;
   localparam int unsigned DEC_PP0_BIT    = 2;
   localparam int unsigned DEC_PP1_BIT    = 6;
   localparam int unsigned DEC_EN_BIT     = 15;
   localparam int unsigned LN_ACKN_BIT    = 4;
   localparam int unsigned LN_INTRQ_BIT   = 5;
   localparam int unsigned LN_DMARQ_BIT   = 6;
   localparam int unsigned WT_EN_BIT      = 0;
   localparam int unsigned WT_LIM_LSB     = 8;
   localparam int unsigned WT_LIM_W       = 8;
   localparam int unsigned PTR_LSB        = 2;

   // ----------------------------------------------------------------
   // Reset values and constants
   // ----------------------------------------------------------------
   localparam logic [7:0]  WT_LIM_RST     = 8'hFF;
   localparam logic [29:0] PTR_RST        = 30'h0000_0000;
   localparam logic [29:0] DESC_STEP      = 30'h0000_0002;
   localparam logic [3:0]  PIN_RST        = 4'hC;

   // ----------------------------------------------------------------
   // Types and helpers
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_RUN  = 2'b01,
      ST_DONE = 2'b10
   } atadma_state_e;

   function automatic logic [31:0] atadma_merge(input logic [31:0] old_w,
                                                input logic [31:0] new_w,
                                                input logic [3:0]  sel);
      logic [31:0] res;
      res = old_w;
      for (int i = 0; i < 4; i++)
      begin
         if (sel[i])
         begin
            res[8*i +: 8] = new_w[8*i +: 8];
         end
      end
      return res;
   endfunction

endpackage

/* File: rtl/atadma_sync.sv */
// Two-stage synchroniser for cable input pins
`timescale 1ns/100ps
`default_nettype none
module atadma_sync
   import atadma_pkg::*;
#(
   parameter int unsigned     W       = 4,
   parameter logic [W-1:0]    RST_VAL = '0
)(
   // Clock and reset
   input  wire logic          clk_i,
   input  wire logic          rst_i,
   // Pins and synchronised levels
   input  wire logic [W-1:0]  pin_i,
   output logic      [W-1:0]  level_o
);

   typedef struct packed {
      logic [W-1:0] stage1;
      logic [W-1:0] stage2;
   } atadma_sync_s;

   atadma_sync_s r;
   atadma_sync_s r_nxt;

   always_comb
   begin
      r_nxt        = r;
      r_nxt.stage1 = pin_i;
      r_nxt.stage2 = r.stage1;
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         r <= {RST_VAL, RST_VAL};
      end
      else
      begin
         r <= r_nxt;
      end
   end

   assign level_o = r.stage2;

endmodule // atadma_sync
`default_nettype wire

/* File: rtl/atadma_wait_timer.sv */
// Wait-line timeout counter for cable strobes
`timescale 1ns/100ps
`default_nettype none
module atadma_wait_timer
   import atadma_pkg::*;
(
   // Clock and reset
   input  wire logic                clk_i,
   input  wire logic                rst_i,
   // Configuration
   input  wire logic                enable_i,
   input  wire logic [WT_LIM_W-1:0] limit_i,
   // Cable state
   input  wire logic                strobe_i,
   input  wire logic                waiting_i,
   // Timeout event
   output logic                     timeout_o
);

   typedef struct packed {
      logic [WT_LIM_W-1:0] count;
      logic                fired;
      logic                pulse;
   } atadma_wt_s;

   atadma_wt_s r;
   atadma_wt_s r_nxt;

   always_comb
   begin
      r_nxt       = r;
      r_nxt.pulse = 1'b0;
      if (!enable_i || !strobe_i || !waiting_i)
      begin
         r_nxt.count = '0;
         r_nxt.fired = 1'b0;
      end
      else if (!r.fired)
      begin
         if (r.count == limit_i)
         begin
            r_nxt.fired = 1'b1;
            r_nxt.pulse = 1'b1;
         end
         else
         begin
            r_nxt.count = r.count + 1'b1;
         end
      end
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         r <= '0;
      end
      else
      begin
         r <= r_nxt;
      end
   end

   assign timeout_o = r.pulse;

endmodule // atadma_wait_timer
`default_nettype wire

/* File: rtl/atadma_ctrl.sv */
// Bus-master DMA control, status and cable decode registers
`timescale 1ns/100ps
`default_nettype none
module atadma_ctrl
   import atadma_pkg::*;
(
   // Clock and reset
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   // Wishbone slave
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [11:0] wb_adr_i,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic [31:0] wb_dat_i,
   output logic      [31:0] wb_dat_o,
   output logic             wb_ack_o,
   // Cable pins
   input  wire logic        dmarq_i,
   input  wire logic        intrq_i,
   input  wire logic        dma_ack_n_i,
   input  wire logic        device_wait_line_i,
   // Datapath events
   input  wire logic        region_done_i,
   input  wire logic        last_descriptor_mark_i,
   input  wire logic        buffer_fault_i,
   input  wire logic        cable_strobe_i,
   input  wire logic        pio_req_i,
   // Datapath control
   output logic             transfer_enable_o,
   output logic             transfer_direction_o,
   output logic             transfer_abort_o,
   output logic             channel_active_o,
   output logic [31:0]      descriptor_table_pointer_o,
   output logic             cable_decode_enable_o,
   output logic             pio_go_o,
   output logic             drive0_buffered_pio_o,
   output logic             drive1_buffered_pio_o
);

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   typedef struct packed {
      logic                ack;
      logic [31:0]         rdata;
      atadma_state_e       st;
      logic                transfer_go;
      logic                transfer_direction;
      logic                channel_active;
      logic                buffer_fault_flag;
      logic                device_irq_flag;
      logic                wait_timeout_flag;
      logic [29:0]         ptr;
      logic                cable_decode_enable;
      logic                drive0_buffered_pio;
      logic                drive1_buffered_pio;
      logic                wt_en;
      logic [WT_LIM_W-1:0] wt_lim;
      logic                intrq_q;
      logic                abort;
   } atadma_ctrl_s;

   atadma_ctrl_s r;
   atadma_ctrl_s r_nxt;

   logic [3:0]        pins;
   logic              dmarq_s;
   logic              intrq_s;
   logic              ackn_s;
   logic              wait_s;
   logic              wt_fire;
   logic              req;
   logic              wr;
   logic [IDX_W-1:0]  idx;
   logic [31:0]       cmd_old;
   logic [31:0]       cmd_new;
   logic [31:0]       clr_mask;
   logic              go_set;
   logic              go_clr;
   logic              done_evt;
   logic [31:0]       rd_word;

   // ----------------------------------------------------------------
   // Pin synchronisers and wait timer
   // ----------------------------------------------------------------
   atadma_sync #(
      .W       (4),
      .RST_VAL (PIN_RST)
   ) u_sync (
      .clk_i   (clk_i),
      .rst_i   (rst_i),
      .pin_i   ({device_wait_line_i, dma_ack_n_i, intrq_i, dmarq_i}),
      .level_o (pins)
   );

   assign dmarq_s = pins[0];
   assign intrq_s = pins[1];
   assign ackn_s  = pins[2];
   assign wait_s  = pins[3];

   atadma_wait_timer u_wtmr (
      .clk_i     (clk_i),
      .rst_i     (rst_i),
      .enable_i  (r.wt_en),
      .limit_i   (r.wt_lim),
      .strobe_i  (cable_strobe_i),
      .waiting_i (!wait_s),
      .timeout_o (wt_fire)
   );

   // ----------------------------------------------------------------
   // Bus decode
   // ----------------------------------------------------------------
   assign req      = wb_cyc_i & wb_stb_i;
   assign wr       = req & wb_we_i & r.ack;
   assign idx      = wb_adr_i[11:2];
   assign clr_mask = atadma_merge(32'h0000_0000, wb_dat_i, wb_sel_i);

   always_comb
   begin
      cmd_old                = '0;
      cmd_old[CMD_GO_BIT]    = r.transfer_go;
      cmd_old[CMD_DIR_BIT]   = r.transfer_direction;
      cmd_new                = atadma_merge(cmd_old, wb_dat_i, wb_sel_i);
   end

   assign go_set = wr & (idx == IDX_DMA_CMD) & cmd_new[CMD_GO_BIT] & !r.transfer_go;
   assign go_clr = wr & (idx == IDX_DMA_CMD) & !cmd_new[CMD_GO_BIT] & r.transfer_go;

   // ----------------------------------------------------------------
   // Read mux
   // ----------------------------------------------------------------
   always_comb
   begin
      rd_word = '0;
      case (idx)
         IDX_DMA_CMD:
         begin
            rd_word[CMD_GO_BIT]  = r.transfer_go;
            rd_word[CMD_DIR_BIT] = r.transfer_direction;
         end
         IDX_DMA_STAT:
         begin
            rd_word[ST_ACT_BIT]  = r.channel_active;
            rd_word[ST_ERR_BIT]  = r.buffer_fault_flag;
            rd_word[ST_IRQ_BIT]  = r.device_irq_flag;
            rd_word[ST_WTO_BIT]  = r.wait_timeout_flag;
         end
         IDX_DESC_PTR:
         begin
            rd_word[31:PTR_LSB]  = r.ptr;
         end
         IDX_DECODE:
         begin
            rd_word[DEC_EN_BIT]  = r.cable_decode_enable;
            rd_word[DEC_PP0_BIT] = r.drive0_buffered_pio;
            rd_word[DEC_PP1_BIT] = r.drive1_buffered_pio;
         end
         IDX_LINE_STAT:
         begin
            rd_word[LN_DMARQ_BIT] = dmarq_s;
            rd_word[LN_INTRQ_BIT] = intrq_s;
            rd_word[LN_ACKN_BIT]  = ackn_s;
         end
         IDX_WAIT_TMR:
         begin
            rd_word[WT_EN_BIT]                     = r.wt_en;
            rd_word[WT_LIM_LSB +: WT_LIM_W]        = r.wt_lim;
         end
         default:
         begin
            rd_word = '0;
         end
      endcase
   end

   // ----------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------
   always_comb
   begin
      r_nxt       = r;
      done_evt    = 1'b0;
      r_nxt.abort = 1'b0;
      r_nxt.ack   = req & !r.ack;
      if (req & !r.ack)
      begin
         r_nxt.rdata = rd_word;
      end
      r_nxt.intrq_q = intrq_s;

      // Transfer sequencing
      case (r.st)
         ST_IDLE:
         begin
            if (go_set)
            begin
               r_nxt.st             = ST_RUN;
               r_nxt.channel_active = 1'b1;
            end
         end
         ST_RUN:
         begin
            if (go_clr)
            begin
               r_nxt.st             = ST_IDLE;
               r_nxt.channel_active = 1'b0;
               r_nxt.abort          = !r.device_irq_flag;
            end
            else if (region_done_i)
            begin
               if (last_descriptor_mark_i)
               begin
                  r_nxt.st             = ST_DONE;
                  r_nxt.channel_active = 1'b0;
                  done_evt             = 1'b1;
               end
               else
               begin
                  r_nxt.ptr = r.ptr + DESC_STEP;
               end
            end
         end
         ST_DONE:
         begin
            if (go_clr)
            begin
               r_nxt.st = ST_IDLE;
            end
         end
         default:
         begin
            r_nxt.st = ST_IDLE;
         end
      endcase

      // Register writes
      if (wr)
      begin
         case (idx)
            IDX_DMA_CMD:
            begin
               r_nxt.transfer_go        = cmd_new[CMD_GO_BIT];
               r_nxt.transfer_direction = cmd_new[CMD_DIR_BIT];
            end
            IDX_DESC_PTR:
            begin
               r_nxt.ptr = 30'(atadma_merge({r.ptr, 2'b00}, wb_dat_i, wb_sel_i) >> PTR_LSB);
            end
            IDX_DECODE:
            begin
               r_nxt.cable_decode_enable = wb_sel_i[1] ? wb_dat_i[DEC_EN_BIT] : r.cable_decode_enable;
               r_nxt.drive0_buffered_pio = wb_sel_i[0] ? wb_dat_i[DEC_PP0_BIT] : r.drive0_buffered_pio;
               r_nxt.drive1_buffered_pio = wb_sel_i[0] ? wb_dat_i[DEC_PP1_BIT] : r.drive1_buffered_pio;
            end
            IDX_WAIT_TMR:
            begin
               r_nxt.wt_en  = wb_sel_i[0] ? wb_dat_i[WT_EN_BIT] : r.wt_en;
               r_nxt.wt_lim = wb_sel_i[1] ? wb_dat_i[WT_LIM_LSB +: WT_LIM_W] : r.wt_lim;
            end
            default:
            begin
               r_nxt.transfer_go = r_nxt.transfer_go;
            end
         endcase
      end

      // Sticky flags, set beats clear
      r_nxt.wait_timeout_flag = (r.wait_timeout_flag
                                 & !(wr & (idx == IDX_DMA_STAT) & clr_mask[ST_WTO_BIT]))
                                | wt_fire;
      r_nxt.device_irq_flag   = (r.device_irq_flag
                                 & !(wr & (idx == IDX_DMA_STAT) & clr_mask[ST_IRQ_BIT]))
                                | (intrq_s & !r.intrq_q)
                                | done_evt;
      r_nxt.buffer_fault_flag = (r.buffer_fault_flag
                                 & !(wr & (idx == IDX_DMA_STAT) & clr_mask[ST_ERR_BIT]))
                                | buffer_fault_i;
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         r        <= '0;
         r.st     <= ST_IDLE;
         r.ptr    <= PTR_RST;
         r.wt_lim <= WT_LIM_RST;
      end
      else
      begin
         r <= r_nxt;
      end
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   assign wb_dat_o                   = r.rdata;
   assign wb_ack_o                   = r.ack;
   assign transfer_enable_o          = r.transfer_go & (r.st == ST_RUN);
   assign transfer_direction_o       = r.transfer_direction;
   assign transfer_abort_o           = r.abort;
   assign channel_active_o           = r.channel_active;
   assign descriptor_table_pointer_o = {r.ptr, 2'b00};
   assign cable_decode_enable_o      = r.cable_decode_enable;
   assign pio_go_o                   = pio_req_i & r.cable_decode_enable;
   assign drive0_buffered_pio_o      = r.drive0_buffered_pio;
   assign drive1_buffered_pio_o      = r.drive1_buffered_pio;

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   sequence s_start;
      (r.st == ST_IDLE) && go_set;
   endsequence

   sequence s_running;
      transfer_enable_o && channel_active_o;
   endsequence

   chk_start_active: assert property (s_start |=> s_running)
      else $error("start did not raise active");
   chk_move_needs_go: assert property (transfer_enable_o |-> r.transfer_go)
      else $error("transfer enabled without go");
   chk_stop_ends: assert property ((r.st == ST_RUN) && go_clr |=> !transfer_enable_o && !channel_active_o
                                   ##1 !transfer_enable_o)
      else $error("stop did not end transfer");
   chk_abort_pulse: assert property ((r.st == ST_RUN) && go_clr && !r.device_irq_flag
                                     |=> transfer_abort_o ##1 !transfer_abort_o)
      else $error("abort pulse missing");
   chk_done_keeps_go: assert property ((r.st == ST_RUN) && region_done_i && last_descriptor_mark_i && !wr
                                       |=> r.transfer_go && r.device_irq_flag && !channel_active_o)
      else $error("completion handling wrong");
   chk_timeout_flag: assert property (wt_fire |=> r.wait_timeout_flag)
      else $error("timeout flag not set");
   chk_irq_edge: assert property (intrq_s && !r.intrq_q |=> r.device_irq_flag)
      else $error("interrupt edge missed");
   chk_fault_flag: assert property (buffer_fault_i |=> r.buffer_fault_flag)
      else $error("fault flag not set");
   chk_w1c_zero: assert property (wr && (idx == IDX_DMA_STAT) && !clr_mask[ST_ERR_BIT] && r.buffer_fault_flag
                                  |=> r.buffer_fault_flag)
      else $error("zero write cleared flag");
   chk_ptr_align: assert property (wb_ack_o && $past(idx) == IDX_DESC_PTR |-> wb_dat_o[1:0] == 2'b00)
      else $error("pointer low bits not zero");
   chk_ptr_advance: assert property ((r.st == ST_RUN) && region_done_i && !last_descriptor_mark_i && !wr && !go_clr
                                     |=> r.ptr == $past(r.ptr) + DESC_STEP)
      else $error("pointer did not advance");
   chk_decode_gate: assert property (pio_go_o |-> cable_decode_enable_o)
      else $error("cable access without decode enable");

endmodule // atadma_ctrl
`default_nettype wire

/* File: tb/atadma_dev_model.sv */
// Behavioural disk device on the cable side of the DMA control block
`timescale 1ns/100ps
`default_nettype none
module atadma_dev_model
(
   // Clock and reset
   input  wire logic clk_i,
   input  wire logic rst_i,
   // Scenario controls
   input  wire logic req_i,
   input  wire logic irq_i,
   input  wire logic stall_i,
   // Cable lines
   output logic      dmarq_o,
   output logic      intrq_o,
   output logic      wait_line_o
);
   // Lines change only after a clock edge; wait line idles high
   always_ff @(posedge clk_i)
   begin
      dmarq_o     <= !rst_i && req_i;
      intrq_o     <= !rst_i && irq_i;
      wait_line_o <= rst_i || !stall_i;
   end
endmodule // atadma_dev_model
`default_nettype wire

/* File: tb/tb.sv */
// Register-level testbench for the DMA control block
`timescale 1ns/100ps
`default_nettype none
module tb;
   logic        clk_i = 1'b0;
   logic        rst_i, cyc, stb, we, ack, dmarq, intrq, ackn, wl;
   logic        rdone, mark, bfault, strobe, pioreq, ten, tdir, tabort, act;
   logic        dec, piogo, pp0, pp1, dreq, dirq, dstall, abort_seen;
   logic [11:0] adr;
   logic [3:0]  sel;
   logic [31:0] dat, dat_o, ptr;
   int          error_cnt, tests_run;

   atadma_ctrl dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
      .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(dat_o), .wb_ack_o(ack),
      .dmarq_i(dmarq), .intrq_i(intrq), .dma_ack_n_i(ackn), .device_wait_line_i(wl),
      .region_done_i(rdone), .last_descriptor_mark_i(mark), .buffer_fault_i(bfault),
      .cable_strobe_i(strobe), .pio_req_i(pioreq), .transfer_enable_o(ten),
      .transfer_direction_o(tdir), .transfer_abort_o(tabort), .channel_active_o(act),
      .descriptor_table_pointer_o(ptr), .cable_decode_enable_o(dec), .pio_go_o(piogo),
      .drive0_buffered_pio_o(pp0), .drive1_buffered_pio_o(pp1));

   atadma_dev_model dev (.clk_i(clk_i), .rst_i(rst_i), .req_i(dreq), .irq_i(dirq),
      .stall_i(dstall), .dmarq_o(dmarq), .intrq_o(intrq), .wait_line_o(wl));

   always #5 clk_i = ~clk_i;

   always @(posedge clk_i)
   begin
      if (rst_i)
         abort_seen <= 1'b0;
      else if (tabort === 1'b1)
         abort_seen <= 1'b1;
   end

   // -------------------------------------------------
   // Bus and checking tasks
   // -------------------------------------------------
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp)
      begin
         error_cnt++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] q);
      @(posedge clk_i);
      cyc <= 1'b1;
      stb <= 1'b1;
      we  <= w;
      sel <= 4'hF;
      adr <= a;
      dat <= d;
      // Wait for ack; only the watchdog ends a hung wait
      do
      begin
         @(posedge clk_i);
      end
      while (ack !== 1'b1);
      q = dat_o;
      cyc <= 1'b0;
      stb <= 1'b0;
   endtask

   // Write commits at the ack edge; one more edge makes it visible
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      logic [31:0] q;
      bus(1'b1, a, d, q);
      @(posedge clk_i);
   endtask

   task automatic rd(input logic [11:0] a, input logic [31:0] exp);
      logic [31:0] q;
      bus(1'b0, a, 32'h0000_0000, q);
      chk(q, exp);
   endtask

   task automatic pulse(input logic r, input logic m, input logic f);
      @(posedge clk_i);
      rdone  <= r;
      mark   <= m;
      bfault <= f;
      @(posedge clk_i);
      rdone  <= 1'b0;
      bfault <= 1'b0;
      repeat (2) @(posedge clk_i);
   endtask

   task automatic note(input string s);
      $display("test %s done", s);
   endtask

   task automatic wrap_up;
      $display("comparisons %0d mismatches %0d", tests_run, error_cnt);
      if (error_cnt == 0 && tests_run > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask

   // -------------------------------------------------
   // Scenarios
   // -------------------------------------------------
   initial
   begin
      rst_i = 1; cyc = 0; stb = 0; we = 0; adr = 0; sel = 4'hF; dat = 0;
      ackn = 1; rdone = 0; mark = 0; bfault = 0; strobe = 0; pioreq = 0;
      dreq = 0; dirq = 0; dstall = 0; error_cnt = 0; tests_run = 0;
      repeat (3) @(posedge clk_i);
      rst_i <= 1'b0;
      rd(12'h000, 32'h0000_0000);
      rd(12'h008, 32'h0000_0000);
      rd(12'h11C, 32'h0000_0010);
      note("reset");
      wr(12'h010, 32'hFFFF_FFFF);
      rd(12'h010, 32'hFFFF_FFFC);
      wr(12'h100, 32'hFFFF_FFFF);
      pioreq <= 1'b1;
      rd(12'h100, 32'h0000_8044);
      chk({dec, piogo, pp0, pp1}, 4'hF);
      wr(12'h100, 32'h0000_0000);
      chk({dec, piogo, pp0, pp1}, 4'h0);
      rd(12'h200, 32'h0000_0000);
      wr(12'h11C, 32'hFFFF_FFFF);
      rd(12'h11C, 32'h0000_0010);
      note("registers");
      wr(12'h010, 32'h0000_1000);
      wr(12'h000, 32'hFFFF_FFF9);
      rd(12'h000, 32'h0000_0009);
      chk({ten, act, tdir}, 3'h7);
      pulse(1'b1, 1'b0, 1'b0);
      chk(ptr, 32'h0000_1008);
      pulse(1'b1, 1'b1, 1'b0);
      chk({ten, act}, 2'h0);
      rd(12'h008, 32'h0000_0004);
      rd(12'h000, 32'h0000_0009);
      wr(12'h008, 32'h0000_0000);
      rd(12'h008, 32'h0000_0004);
      wr(12'h008, 32'h0000_0004);
      wr(12'h000, 32'h0000_0008);
      chk(abort_seen, 1'b0);
      note("transfer");
      wr(12'h000, 32'h0000_0001);
      chk({ten, act}, 2'h3);
      wr(12'h000, 32'h0000_0000);
      repeat (2) @(posedge clk_i);
      chk({abort_seen, ten, act}, 3'h4);
      pulse(1'b1, 1'b1, 1'b0);
      rd(12'h008, 32'h0000_0000);
      note("abort");
      pulse(1'b0, 1'b0, 1'b1);
      rd(12'h008, 32'h0000_0002);
      wr(12'h008, 32'h0000_0002);
      dirq <= 1'b1;
      dreq <= 1'b1;
      ackn <= 1'b0;
      repeat (5) @(posedge clk_i);
      rd(12'h008, 32'h0000_0004);
      rd(12'h11C, 32'h0000_0060);
      dirq <= 1'b0;
      dreq <= 1'b0;
      ackn <= 1'b1;
      wr(12'h008, 32'h0000_0004);
      rd(12'h008, 32'h0000_0000);
      note("flags");
      wr(12'h0F0, 32'h0000_0401);
      dstall <= 1'b1;
      strobe <= 1'b1;
      repeat (20) @(posedge clk_i);
      strobe <= 1'b0;
      dstall <= 1'b0;
      rd(12'h008, 32'h0000_0008);
      wr(12'h008, 32'h0000_0008);
      rd(12'h008, 32'h0000_0000);
      note("timeout");
      wrap_up();
   end

   initial
   begin
      repeat (5000) @(posedge clk_i);
      error_cnt++;
      wrap_up();
   end
endmodule // tb
`default_nettype wire
